//--- hw/tmc8_map.svh
/*
  Register offsets, field positions, reset values and prescaler
  exponents of the eight-bit four-mode timer/counter.
  Assumes it is included by its bare name from the hw/ folder.
*/
`ifndef TMC8_MAP_SVH
`define TMC8_MAP_SVH

// Register offsets on the plain register port
`define TMC8_ADDR_CTL 8'h14
`define TMC8_ADDR_CMP 8'h18

// Reset values
`define TMC8_CMP_RST 8'hff
`define TMC8_CTL_RST 6'h00

// Field positions inside timer_control
`define TMC8_CTL_MODE_LSB 0
`define TMC8_CTL_SRC_LSB 2
`define TMC8_CTL_RUN_BIT 5

// Mode field codes
`define TMC8_MODE_TMR 2'b00
`define TMC8_MODE_RSVD 2'b01
`define TMC8_MODE_PDO 2'b10
`define TMC8_MODE_PWM 2'b11

// Source clock select: 3'h7 is the event pin
`define TMC8_SRC_EXT 3'h7

// Prescaler: divide ref_clk by two to these powers for selects 0..6
`define TMC8_PRE_W 12
`define TMC8_DIV_SEL0 4'd11
`define TMC8_DIV_SEL1 4'd7
`define TMC8_DIV_SEL2 4'd5
`define TMC8_DIV_SEL3 4'd3
`define TMC8_DIV_SEL4 4'd2
`define TMC8_DIV_SEL5 4'd1
`define TMC8_DIV_SEL6 4'd0

`endif

//--- hw/tmc8_pkg.sv
/*
  Types shared by the eight-bit four-mode timer/counter.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tmc8_pkg;

  typedef struct packed {
    logic run;
    logic [2:0] src;
    logic [1:0] mode;
  } tmc8_ctl_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmc8_bus_s;

endpackage

//--- hw/tmc8_top.sv
/*
  Eight-bit up-counting timer/counter: timer, event counter,
  divider output and PWM output on one counter, with its own
  prescaler of ref_clk and a plain register port.
  Assumes all inputs synchronous to ref_clk and a register master
  that pulses wr or rd for one cycle, never both.
*/
// Behaviour
// - Four modes share one counter
// - Timer mode: match interrupts, clears, keeps counting
// - Event mode counts rising edges of pin
// - Event mode match detected on falling edge
// - After event match restart from zero
// - Divider mode gives 50% square wave
// - Divider match toggles pin, interrupts, clears
// - Divider pin high while stopped
// - PWM mode with eight bits of resolution
// - PWM duty match drives pin low
// - PWM overflow drives pin high, interrupts
// - PWM pin high while stopped
// - PWM compare buffered until cycle end
// - Start loads compare into PWM stage
// - Mode field decode, code 01 reserved
// - Stop power mode clears run control
`include "tmc8_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tmc8_top #(
  parameter int PRE_W = `TMC8_PRE_W
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire tmc8_pkg::tmc8_bus_s bus_req,
  output logic [7:0] rd_data,
  input wire logic event_input_pin,
  input wire logic stop_mode_entry,
  output logic match_interrupt,
  output logic divider_output_pin,
  output logic pwm_output_n
);
  import tmc8_pkg::*;

  tmc8_ctl_s ctl_r, ctl_nxt;
  logic [7:0] cmp_r, cmp_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic [PRE_W-1:0] pre_r, pre_nxt, pre_mask;
  logic [7:0] cnt_r, cnt_nxt, cnt_inc;
  logic [7:0] duty_r, duty_nxt;
  logic ev_d_r, ev_rise, ev_fall;
  logic irq_r, irq_nxt;
  logic pdo_r, pdo_nxt;
  logic pwm_n_r, pwm_n_nxt;
  logic tick;
  logic evt_mode;

  // Register port: read data valid the cycle after rd only
  always_comb begin
    ctl_nxt = ctl_r;
    cmp_nxt = cmp_r;
    rd_data_nxt = 8'h00;
    if (bus_req.wr) begin
      if (bus_req.addr == `TMC8_ADDR_CTL) begin
        ctl_nxt = tmc8_ctl_s'(bus_req.wdata[5:0]);
      end else if (bus_req.addr == `TMC8_ADDR_CMP) begin
        cmp_nxt = bus_req.wdata;
      end
    end
    if (bus_req.rd) begin
      if (bus_req.addr == `TMC8_ADDR_CTL) begin
        rd_data_nxt = {2'b00, ctl_r};
      end else if (bus_req.addr == `TMC8_ADDR_CMP) begin
        rd_data_nxt = cmp_r;
      end else begin
        rd_data_nxt = 8'h00;
      end
    end
    // Power-mode entry beats a coincident software start
    if (stop_mode_entry) begin
      ctl_nxt.run = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= tmc8_ctl_s'(`TMC8_CTL_RST);
      cmp_r <= `TMC8_CMP_RST;
      rd_data_r <= 8'h00;
    end else begin
      ctl_r <= ctl_nxt;
      cmp_r <= cmp_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // Prescaler: free running so the first tick after start may be early
  always_comb begin
    pre_nxt = pre_r + PRE_W'(1);
    case (ctl_r.src)
      3'h0: pre_mask = PRE_W'((1 << `TMC8_DIV_SEL0) - 1);
      3'h1: pre_mask = PRE_W'((1 << `TMC8_DIV_SEL1) - 1);
      3'h2: pre_mask = PRE_W'((1 << `TMC8_DIV_SEL2) - 1);
      3'h3: pre_mask = PRE_W'((1 << `TMC8_DIV_SEL3) - 1);
      3'h4: pre_mask = PRE_W'((1 << `TMC8_DIV_SEL4) - 1);
      3'h5: pre_mask = PRE_W'((1 << `TMC8_DIV_SEL5) - 1);
      3'h6: pre_mask = PRE_W'((1 << `TMC8_DIV_SEL6) - 1);
      default: pre_mask = '1;
    endcase
    tick = ((pre_r & pre_mask) == pre_mask) && (ctl_r.src != `TMC8_SRC_EXT);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // Event pin edges; pin is already synchronous
  assign ev_rise = event_input_pin && !ev_d_r;
  assign ev_fall = !event_input_pin && ev_d_r;
  assign evt_mode = (ctl_r.mode == `TMC8_MODE_TMR) && (ctl_r.src == `TMC8_SRC_EXT);
  assign cnt_inc = cnt_r + 8'h01;

  // Counter, pins and PWM shift stage
  always_comb begin
    cnt_nxt = cnt_r;
    irq_nxt = 1'b0;
    pdo_nxt = pdo_r;
    pwm_n_nxt = pwm_n_r;
    duty_nxt = duty_r;
    if (!ctl_r.run) begin
      cnt_nxt = 8'h00;
      pdo_nxt = 1'b1;
      pwm_n_nxt = 1'b1;
      // Stage tracks compare so the first cycle after start uses it
      duty_nxt = cmp_r;
    end else begin
      case (ctl_r.mode)
        `TMC8_MODE_TMR: begin
          if (evt_mode) begin
            if (ev_rise) begin
              cnt_nxt = cnt_inc;
            end else if (ev_fall && (cnt_r == cmp_r)) begin
              cnt_nxt = 8'h00;
              irq_nxt = 1'b1;
            end
          end else if (tick) begin
            if (cnt_inc == cmp_r) begin
              cnt_nxt = 8'h00;
              irq_nxt = 1'b1;
            end else begin
              cnt_nxt = cnt_inc;
            end
          end
        end
        `TMC8_MODE_PDO: begin
          if (tick) begin
            if (cnt_inc == cmp_r) begin
              cnt_nxt = 8'h00;
              irq_nxt = 1'b1;
              pdo_nxt = !pdo_r;
            end else begin
              cnt_nxt = cnt_inc;
            end
          end
        end
        `TMC8_MODE_PWM: begin
          if (tick) begin
            cnt_nxt = cnt_inc;
            if (cnt_r == 8'hff) begin
              pwm_n_nxt = 1'b1;
              irq_nxt = 1'b1;
              // New duty only at cycle end, never mid-cycle
              duty_nxt = cmp_r;
            end else if (cnt_inc == duty_r) begin
              pwm_n_nxt = 1'b0;
            end
          end
        end
        default: begin
          // Reserved code: counter holds, pins stay put
          cnt_nxt = cnt_r;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
      duty_r <= `TMC8_CMP_RST;
      ev_d_r <= 1'b0;
      irq_r <= 1'b0;
      pdo_r <= 1'b1;
      pwm_n_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      duty_r <= duty_nxt;
      ev_d_r <= event_input_pin;
      irq_r <= irq_nxt;
      pdo_r <= pdo_nxt;
      pwm_n_r <= pwm_n_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign match_interrupt = irq_r;
  assign divider_output_pin = pdo_r;
  assign pwm_output_n = pwm_n_r;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_evt_match;
    ctl_r.run && evt_mode && ev_fall && (cnt_r == cmp_r);
  endsequence

  sequence s_pwm_ovf;
    ctl_r.run && (ctl_r.mode == `TMC8_MODE_PWM) && tick && (cnt_r == 8'hff);
  endsequence

  sequence s_pwm_cycle_end;
    pwm_output_n && match_interrupt && (cnt_r == 8'h00);
  endsequence

  a_stop_pins_high: assert property (!ctl_r.run |=> divider_output_pin && pwm_output_n)
    else $error("pins not high while stopped");

  a_stop_cnt_clear: assert property (!ctl_r.run |=> cnt_r == 8'h00)
    else $error("counter not cleared while stopped");

  a_tmr_match: assert property (ctl_r.run && (ctl_r.mode == `TMC8_MODE_TMR) && !evt_mode
      && tick && (cnt_inc == cmp_r) |=> match_interrupt && (cnt_r == 8'h00))
    else $error("timer match missed");

  a_evt_count_up: assert property (ctl_r.run && evt_mode && ev_rise
      |=> cnt_r == 8'($past(cnt_r) + 8'h01))
    else $error("event rise did not count");

  a_evt_match_fall: assert property (s_evt_match |=> match_interrupt && (cnt_r == 8'h00))
    else $error("event match not on falling edge");

  a_evt_no_rise_irq: assert property (evt_mode && ev_rise |=> !match_interrupt)
    else $error("event interrupt on rising edge");

  a_pdo_toggle: assert property (ctl_r.run && (ctl_r.mode == `TMC8_MODE_PDO) && tick
      && (cnt_inc == cmp_r) |=> (divider_output_pin != $past(divider_output_pin))
      && match_interrupt)
    else $error("divider pin did not toggle on match");

  a_pwm_duty_low: assert property (ctl_r.run && (ctl_r.mode == `TMC8_MODE_PWM) && tick
      && (cnt_r != 8'hff) && (cnt_inc == duty_r) |=> !pwm_output_n)
    else $error("pwm pin not low at duty match");

  a_pwm_overflow: assert property (s_pwm_ovf |=> s_pwm_cycle_end)
    else $error("pwm overflow not handled");

  a_pwm_reload: assert property (s_pwm_ovf ##1 ctl_r.run |-> duty_r == $past(cmp_r))
    else $error("pwm stage not reloaded at cycle end");

  a_pwm_hold: assert property (ctl_r.run && !(tick && (cnt_r == 8'hff))
      ##1 ctl_r.run |-> duty_r == $past(duty_r))
    else $error("pwm stage changed mid-cycle");

  a_start_load: assert property (!ctl_r.run ##1 ctl_r.run |-> duty_r == $past(cmp_r))
    else $error("start did not load pwm stage");

  a_stop_entry: assert property (stop_mode_entry |=> !ctl_r.run)
    else $error("stop mode did not clear run");

  a_rsvd_hold: assert property (ctl_r.run && (ctl_r.mode == `TMC8_MODE_RSVD) ##1 ctl_r.run
      |-> cnt_r == $past(cnt_r) && !match_interrupt)
    else $error("reserved mode counted");

  a_read_cmp: assert property (bus_req.rd && (bus_req.addr == `TMC8_ADDR_CMP)
      |=> rd_data == $past(cmp_r))
    else $error("compare read wrong");

  // Upper two control bits always read as zero
  a_read_ctl: assert property (bus_req.rd && (bus_req.addr == `TMC8_ADDR_CTL)
      |=> rd_data == {2'b00, $past(ctl_r)})
    else $error("control read wrong");

  a_tmr_count_up: assert property (ctl_r.run && (ctl_r.mode == `TMC8_MODE_TMR)
      && !evt_mode && tick && (cnt_inc != cmp_r) |=> cnt_r == 8'($past(cnt_r) + 8'h01))
    else $error("timer tick did not count");

  // Duty match must not clear the counter, only overflow wraps it
  a_pwm_no_clear: assert property (ctl_r.run && (ctl_r.mode == `TMC8_MODE_PWM)
      && tick |=> cnt_r == 8'($past(cnt_r) + 8'h01))
    else $error("pwm counter did not keep running");

  a_idle_no_irq: assert property (!ctl_r.run |=> !match_interrupt)
    else $error("interrupt while stopped");

endmodule

`default_nettype wire

//--- tb/tmc8_pulse_src.sv
/*
  Event pulse source that drives the timer's event input pin.
  Assumes one ref_clk domain; the pin idles low while disabled.
*/
`timescale 1ns/1ps
`default_nettype none
module tmc8_pulse_src (
  input wire logic ref_clk,
  input wire logic en,
  input wire logic [7:0] half,
  output var logic pin
);
  logic [7:0] cnt_r = 8'h00;
  initial pin = 1'b0;
  // Phases never shorter than nine clocks, whatever half says
  always @(posedge ref_clk) begin
    if (!en) begin
      cnt_r <= 8'h00;
      pin <= 1'b0;
    end else if (cnt_r >= half - 8'h01 && cnt_r >= 8'h08) begin
      cnt_r <= 8'h00;
      pin <= ~pin;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- tb/tb_tmc8_top.sv
/*
  Self-checking bench of the four-mode timer/counter.
  Assumes the design and its register map from hw/.
*/
`include "tmc8_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_tmc8_top;
  import tmc8_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic stop_mode_entry = 1'b0;
  logic ev_en = 1'b0;
  tmc8_bus_s bus_req = '0;
  logic [7:0] rd_data;
  logic event_input_pin, match_interrupt, divider_output_pin, pwm_output_n;
  int fails = 0;
  int samples_checked = 0;
  tmc8_top tmc8_top_i (.ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req),
    .rd_data(rd_data), .event_input_pin(event_input_pin),
    .stop_mode_entry(stop_mode_entry), .match_interrupt(match_interrupt),
    .divider_output_pin(divider_output_pin), .pwm_output_n(pwm_output_n));
  tmc8_pulse_src tmc8_pulse_src_i (.ref_clk(ref_clk), .en(ev_en), .half(8'h0a),
    .pin(event_input_pin));
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    bus_req <= '0;
    @(negedge ref_clk);
    cmp8(rd_data, exp);
  endtask
  // Bounded wait for the next interrupt; also counts low PWM cycles
  task automatic wait_irq(output int n, output int lo);
    n = 0;
    lo = 0;
    do begin
      @(negedge ref_clk);
      n++;
      if (pwm_output_n === 1'b0) lo++;
    end while (match_interrupt !== 1'b1 && n < 600);
    if (match_interrupt !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask
  // Mode and source set while stopped, then run
  task automatic start(input logic [1:0] m, input logic [2:0] s, input logic [7:0] c);
    wr(`TMC8_ADDR_CTL, {3'b000, s, m});
    wr(`TMC8_ADDR_CMP, c);
    wr(`TMC8_ADDR_CTL, {3'b001, s, m});
  endtask
  task automatic s_reset();
    rd(`TMC8_ADDR_CMP, `TMC8_CMP_RST);
    rd(`TMC8_ADDR_CTL, 8'h00);
    rd(8'h20, 8'h00);
    cmp8({6'h00, divider_output_pin, pwm_output_n}, 8'h03);
  endtask
  task automatic s_timer(input logic [7:0] c);
    int n, lo;
    start(`TMC8_MODE_TMR, 3'h6, c);
    wait_irq(n, lo);
    wait_irq(n, lo);
    cmp8(8'(n), c);
    wr(`TMC8_ADDR_CTL, 8'h18);
  endtask
  task automatic s_rsvd();
    int k;
    k = 0;
    start(`TMC8_MODE_RSVD, 3'h6, 8'h03);
    repeat (40) begin
      @(negedge ref_clk);
      if (match_interrupt !== 1'b0) k++;
    end
    cmp8(8'(k), 8'h00);
    wr(`TMC8_ADDR_CTL, 8'h19);
  endtask
  task automatic s_pdo();
    int n, lo;
    logic d0;
    start(`TMC8_MODE_PDO, 3'h6, 8'h05);
    wait_irq(n, lo);
    d0 = divider_output_pin;
    cmp8({7'h00, d0}, 8'h00);
    wait_irq(n, lo);
    cmp8(8'(n), 8'h05);
    cmp8({7'h00, divider_output_pin}, {7'h00, ~d0});
    // Stop while low so the forced high level is really seen
    wait_irq(n, lo);
    wr(`TMC8_ADDR_CTL, 8'h1a);
    repeat (2) @(negedge ref_clk);
    cmp8({7'h00, divider_output_pin}, 8'h01);
  endtask
  task automatic s_event();
    int n, lo;
    ev_en <= 1'b1;
    start(`TMC8_MODE_TMR, `TMC8_SRC_EXT, 8'h02);
    wait_irq(n, lo);
    wait_irq(n, lo);
    cmp8(8'(n), 8'd40);
    cmp8({7'h00, event_input_pin}, 8'h00);
    wr(`TMC8_ADDR_CTL, 8'h1c);
    ev_en <= 1'b0;
  endtask
  task automatic s_pwm();
    int n, lo;
    start(`TMC8_MODE_PWM, 3'h6, 8'h40);
    wait_irq(n, lo);
    cmp8(8'(lo), 8'd192);
    wr(`TMC8_ADDR_CMP, 8'hc0);
    wait_irq(n, lo);
    cmp8(8'(lo), 8'd192);
    cmp8({7'h00, pwm_output_n}, 8'h01);
    wait_irq(n, lo);
    cmp8(8'(n - 1), 8'hff);
    cmp8(8'(lo), 8'd64);
    repeat (200) @(posedge ref_clk);
    stop_mode_entry <= 1'b1;
    @(posedge ref_clk);
    stop_mode_entry <= 1'b0;
    rd(`TMC8_ADDR_CTL, 8'h1b);
    cmp8({7'h00, pwm_output_n}, 8'h01);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    s_reset();
    s_timer(8'h01);
    s_timer(8'h03);
    s_rsvd();
    s_pdo();
    s_event();
    s_pwm();
    stop_test();
  end
endmodule
`default_nettype wire
